//--- bus_watchdog_failsafe.sv
`timescale 1ns/1ns
// Notes on behaviour
// - Fail selector: 0 hold,1 close,2 open,3 mid
// - No supervision out of reset; setpoint kept
// - Setpoint, override or timeout writes restart watchdog
// - Expiry with nonzero selector commands fail motion
// - Timeout 0..3600 seconds; zero disables watchdog
// - Timeout resets 0; becomes 120 with selector
// - Expiry sets watchdog bit in fault register
// - Analog source keeps bus monitoring inactive
// - Source selector: 0 analog, 1 bus, reset 1
// - Power loss: hold for bridging time first
// - Then move to fail-safe position, 0..10000
// - Watchdog indication is fault bit ten
module bus_watchdog_failsafe #(
    parameter int CYCLES_PER_SEC = wdog_cfg_pkg::CYCLES_PER_SEC
) (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_rstn,
    // Register access from the frame decoder
    input wire logic [15:0] i_reg_addr,
    input wire logic i_reg_wr,
    input wire logic [15:0] i_reg_wdata,
    input wire logic i_reg_rd,
    output logic [15:0] o_reg_rdata,
    output logic o_reg_rvalid,
    // Fault bits owned by other blocks
    input wire logic [15:0] i_other_fault_bits,
    // Pins
    input wire logic i_power_fail,
    input wire logic i_efs_variant,
    // Actuator commands and status
    output logic o_bus_fail_active,
    output logic [1:0] o_bus_fail_mode,
    output logic o_wdog_trip,
    output logic o_setpoint_origin_select,
    output logic o_bridge_hold,
    output logic o_failsafe_move,
    output logic [15:0] o_failsafe_position
);
    wdog_cfg_pkg::fail_pos_t fail_pos_q;
    wdog_cfg_pkg::sp_source_t src_q;
    logic [15:0] wd_timeout_q, bridge_q, fs_pos_q, rdata_q;
    logic timeout_set_q, trip_q, fail_active_q, rvalid_q;
    logic pf_meta_q, pf_q, pf_prev_q;
    logic efs_meta_q, efs_q;
    logic hold_q, move_q;
    logic renew, to_write, fp_write, supervise;
    sec_timer_if wd_if ();
    sec_timer_if br_if ();
    // All checks sample on the core clock and sleep while reset is held
    default clocking @(posedge i_core_clk);
    endclocking
    default disable iff (!i_rstn);
    function automatic logic wr_to(input logic [15:0] a, input logic [15:0] want);
        wr_to = i_reg_wr && (a == want);
    endfunction
    // Write decode; out-of-range values are ignored so settings stay legal
    assign renew = wr_to(i_reg_addr, wdog_cfg_pkg::ADDR_SETPOINT)
        || wr_to(i_reg_addr, wdog_cfg_pkg::ADDR_OVERRIDE);
    assign to_write = wr_to(i_reg_addr, wdog_cfg_pkg::ADDR_WD_TIMEOUT)
        && (i_reg_wdata <= wdog_cfg_pkg::WD_TIMEOUT_MAX);
    assign fp_write = wr_to(i_reg_addr, wdog_cfg_pkg::ADDR_FAIL_POS)
        && (i_reg_wdata <= wdog_cfg_pkg::FAIL_POS_MAX);
    // Supervision needs a nonzero timeout and the bus as setpoint source
    assign supervise = (wd_timeout_q != 16'h0000)
        && (src_q == wdog_cfg_pkg::SRC_BUS);
    // Watchdog timer hookup; a new limit restarts the count
    assign wd_if.start = renew || to_write;
    assign wd_if.run = supervise;
    assign wd_if.limit_s = wd_timeout_q;
    sec_timer #(.CYCLES_PER_SEC(CYCLES_PER_SEC)) u_wd_timer
    (
        .i_core_clk(i_core_clk),
        .i_rstn(i_rstn),
        .t(wd_if.timer)
    );
    // Fail position selector, with the 120 s default applied on first use
    always_ff @(posedge i_core_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            fail_pos_q <= wdog_cfg_pkg::RST_FAIL_POS;
        end
        else if (fp_write)
        begin
            fail_pos_q <= wdog_cfg_pkg::fail_pos_t'(i_reg_wdata[1:0]);
        end
    end
    // Timeout register; only an untouched zero picks up the default
    always_ff @(posedge i_core_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            wd_timeout_q <= wdog_cfg_pkg::RST_WD_TIMEOUT;
            timeout_set_q <= 1'b0;
        end
        else if (to_write)
        begin
            wd_timeout_q <= i_reg_wdata;
            timeout_set_q <= 1'b1;
        end
        else if (fp_write && (i_reg_wdata != 16'h0000) && !timeout_set_q
            && (wd_timeout_q == 16'h0000))
        begin
            wd_timeout_q <= wdog_cfg_pkg::WD_TIMEOUT_FAIL_DEFAULT;
        end
    end
    // Source selector and power-loss settings
    always_ff @(posedge i_core_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            src_q <= wdog_cfg_pkg::RST_SP_SOURCE;
            bridge_q <= wdog_cfg_pkg::RST_BRIDGE_TIME;
            fs_pos_q <= wdog_cfg_pkg::RST_FS_POS;
        end
        else
        begin
            if (wr_to(i_reg_addr, wdog_cfg_pkg::ADDR_SP_SOURCE)
                && (i_reg_wdata <= wdog_cfg_pkg::SP_SOURCE_MAX))
            begin
                src_q <= wdog_cfg_pkg::sp_source_t'(i_reg_wdata[0]);
            end
            if (wr_to(i_reg_addr, wdog_cfg_pkg::ADDR_BRIDGE_TIME)
                && (i_reg_wdata <= wdog_cfg_pkg::BRIDGE_TIME_MAX))
            begin
                bridge_q <= i_reg_wdata;
            end
            if (wr_to(i_reg_addr, wdog_cfg_pkg::ADDR_FS_POS)
                && (i_reg_wdata <= wdog_cfg_pkg::FS_POS_MAX))
            begin
                fs_pos_q <= i_reg_wdata;
            end
        end
    end
    // Trip flag: a clearing renew wins, as its restart masks expiry in the same cycle
    always_ff @(posedge i_core_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            trip_q <= 1'b0;
            fail_active_q <= 1'b0;
        end
        else
        begin
            if (wd_if.expired)
            begin
                trip_q <= 1'b1;
            end
            else if (renew)
            begin
                trip_q <= 1'b0;
            end
            // Selector 0 keeps the last setpoint, so no motion is commanded
            fail_active_q <= wd_if.expired
                && (fail_pos_q != wdog_cfg_pkg::FAIL_HOLD);
        end
    end
    // Pin synchronisers for power fail and variant strap
    always_ff @(posedge i_core_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            pf_meta_q <= 1'b0;
            pf_q <= 1'b0;
            pf_prev_q <= 1'b0;
            efs_meta_q <= 1'b0;
            efs_q <= 1'b0;
        end
        else
        begin
            pf_meta_q <= i_power_fail;
            pf_q <= pf_meta_q;
            pf_prev_q <= pf_q;
            efs_meta_q <= i_efs_variant;
            efs_q <= efs_meta_q;
        end
    end
    // Bridging timer starts on the power-fail edge, electronic variants only
    assign br_if.start = pf_q && !pf_prev_q;
    assign br_if.run = pf_q && efs_q;
    assign br_if.limit_s = bridge_q;

    sec_timer #(.CYCLES_PER_SEC(CYCLES_PER_SEC)) u_br_timer
    (
        .i_core_clk(i_core_clk),
        .i_rstn(i_rstn),
        .t(br_if.timer)
    );
    // Hold during bridging (none for a zero time), then move to the fail-safe position
    always_ff @(posedge i_core_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            hold_q <= 1'b0;
            move_q <= 1'b0;
        end
        else
        begin
            hold_q <= br_if.run && !br_if.expired && (bridge_q != 16'h0000);
            move_q <= br_if.expired;
        end
    end
    // Registered read port; foreign addresses answer as deactivated
    always_ff @(posedge i_core_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            rdata_q <= 16'h0000;
            rvalid_q <= 1'b0;
        end
        else
        begin
            rvalid_q <= i_reg_rd;
            if (i_reg_rd)
            begin
                case (i_reg_addr)
                    wdog_cfg_pkg::ADDR_FAULT_INFO:
                    begin
                        rdata_q <= i_other_fault_bits;
                        rdata_q[wdog_cfg_pkg::FAULT_WDOG_BIT] <= trip_q;
                    end
                    wdog_cfg_pkg::ADDR_FAIL_POS: rdata_q <= {14'h0000, fail_pos_q};
                    wdog_cfg_pkg::ADDR_WD_TIMEOUT: rdata_q <= wd_timeout_q;
                    wdog_cfg_pkg::ADDR_SP_SOURCE: rdata_q <= {15'h0000, src_q};
                    wdog_cfg_pkg::ADDR_BRIDGE_TIME: rdata_q <= bridge_q;
                    wdog_cfg_pkg::ADDR_FS_POS: rdata_q <= fs_pos_q;
                    default: rdata_q <= wdog_cfg_pkg::REG_DEACTIVATED;
                endcase
            end
        end
    end
    // Outputs
    assign o_reg_rdata = rdata_q;
    assign o_reg_rvalid = rvalid_q;
    assign o_bus_fail_active = fail_active_q;
    assign o_bus_fail_mode = fail_pos_q;
    assign o_wdog_trip = trip_q;
    assign o_setpoint_origin_select = src_q;
    assign o_bridge_hold = hold_q;
    assign o_failsafe_move = move_q;
    assign o_failsafe_position = fs_pos_q;
    // Checks
    property p_fail_mode;
        fp_write && (i_reg_wdata == 16'h0002) |=> (o_bus_fail_mode == 2'b10);
    endproperty
    a_fail_mode: assert property (p_fail_mode) else $error("mode not taken");
    property p_zero_timeout;
        (wd_timeout_q == 16'h0000) |=> !o_bus_fail_active;
    endproperty
    a_zero_timeout: assert property (p_zero_timeout) else $error("zero timeout moved");
    property p_other_traffic;
        trip_q && i_reg_wr && !renew |=> o_wdog_trip;
    endproperty
    a_other_traffic: assert property (p_other_traffic) else $error("trip cleared");
    property p_fail_cmd;
        wd_if.expired && (fail_pos_q != wdog_cfg_pkg::FAIL_HOLD) |=> o_bus_fail_active;
    endproperty
    a_fail_cmd: assert property (p_fail_cmd) else $error("no fail motion");
    property p_default_120;
        fp_write && (i_reg_wdata != 16'h0000) && !timeout_set_q && !to_write
            && (wd_timeout_q == 16'h0000) |=> (wd_timeout_q == 16'h0078);
    endproperty
    a_default_120: assert property (p_default_120) else $error("no default");
    property p_trip_flag;
        wd_if.expired |=> o_wdog_trip;
    endproperty
    a_trip_flag: assert property (p_trip_flag) else $error("expiry not flagged");
    property p_analog_off;
        (src_q == wdog_cfg_pkg::SRC_ANALOG) |-> !wd_if.expired ##1 !o_bus_fail_active;
    endproperty
    a_analog_off: assert property (p_analog_off) else $error("analog supervised");
    property p_source_write;
        i_reg_wr && (i_reg_addr == wdog_cfg_pkg::ADDR_SP_SOURCE) && (i_reg_wdata == 16'h0000)
            |=> !o_setpoint_origin_select;
    endproperty
    a_source_write: assert property (p_source_write) else $error("source not set");
    property p_bridge_hold;
        $rose(pf_q) && efs_q && (bridge_q != 16'h0000) |=> !o_failsafe_move ##1 o_bridge_hold;
    endproperty
    a_bridge_hold: assert property (p_bridge_hold) else $error("moved too early");
    property p_fault_bit;
        i_reg_rd && (i_reg_addr == wdog_cfg_pkg::ADDR_FAULT_INFO)
            |=> (o_reg_rdata[wdog_cfg_pkg::FAULT_WDOG_BIT] == $past(trip_q));
    endproperty
    a_fault_bit: assert property (p_fault_bit) else $error("bit ten wrong");
    property p_timeout_restart;
        to_write && (i_reg_wdata != 16'h0000) |=> !wd_if.expired;
    endproperty
    a_timeout_restart: assert property (p_timeout_restart) else $error("no restart");
endmodule

//--- wdog_cfg_pkg.sv
package wdog_cfg_pkg;

    // Register addresses (zero-based holding register addresses)
    localparam logic [15:0] ADDR_SETPOINT = 16'h0000;
    localparam logic [15:0] ADDR_OVERRIDE = 16'h0001;
    localparam logic [15:0] ADDR_FAULT_INFO = 16'h0068;
    localparam logic [15:0] ADDR_FAIL_POS = 16'h006C;
    localparam logic [15:0] ADDR_WD_TIMEOUT = 16'h006D;
    localparam logic [15:0] ADDR_SP_SOURCE = 16'h0076;
    localparam logic [15:0] ADDR_BRIDGE_TIME = 16'h00BD;
    localparam logic [15:0] ADDR_FS_POS = 16'h00BE;

    // Field positions
    localparam int FAULT_WDOG_BIT = 10;

    // Value ranges and defaults
    localparam logic [15:0] WD_TIMEOUT_MAX = 16'h0E10;
    localparam logic [15:0] WD_TIMEOUT_FAIL_DEFAULT = 16'h0078;
    localparam logic [15:0] BRIDGE_TIME_MAX = 16'h000A;
    localparam logic [15:0] FS_POS_MAX = 16'h2710;
    localparam logic [15:0] FAIL_POS_MAX = 16'h0003;
    localparam logic [15:0] SP_SOURCE_MAX = 16'h0001;
    localparam logic [15:0] REG_DEACTIVATED = 16'hFFFF;

    // Reset values
    localparam logic [15:0] RST_WD_TIMEOUT = 16'h0000;
    localparam logic [15:0] RST_BRIDGE_TIME = 16'h0000;
    localparam logic [15:0] RST_FS_POS = 16'h0000;

    // Timing
    localparam int CLK_PERIOD_NS = 4;
    localparam int SECOND_NS = 1000000000;
    localparam int CYCLES_PER_SEC = SECOND_NS / CLK_PERIOD_NS;

    typedef enum logic [1:0]
    {
        FAIL_HOLD = 2'b00,
        FAIL_CLOSE = 2'b01,
        FAIL_OPEN = 2'b10,
        FAIL_MID = 2'b11
    } fail_pos_t;

    typedef enum logic
    {
        SRC_ANALOG = 1'b0,
        SRC_BUS = 1'b1
    } sp_source_t;

    localparam fail_pos_t RST_FAIL_POS = FAIL_HOLD;
    localparam sp_source_t RST_SP_SOURCE = SRC_BUS;

endpackage

//--- sec_timer_if.sv
`timescale 1ns/1ns
interface sec_timer_if;
    logic start;
    logic run;
    logic [15:0] limit_s;
    logic expired;

    modport timer
    (
        input start,
        input run,
        input limit_s,
        output expired
    );

    modport user
    (
        output start,
        output run,
        output limit_s,
        input expired
    );
endinterface

//--- sec_timer.sv
`timescale 1ns/1ns
module sec_timer #(
    parameter int CYCLES_PER_SEC = wdog_cfg_pkg::CYCLES_PER_SEC
) (
    input wire logic i_core_clk,
    input wire logic i_rstn,
    sec_timer_if.timer t
);
    logic [31:0] pre_q;
    logic [15:0] sec_q;

    // Expiry holds until restart or until the timer is stopped
    assign t.expired = t.run && !t.start && (sec_q >= t.limit_s);

    // Prescaler and seconds count; counting freezes once expired
    always_ff @(posedge i_core_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            pre_q <= 32'h0000_0000;
            sec_q <= 16'h0000;
        end
        else if (t.start || !t.run)
        begin
            pre_q <= 32'h0000_0000;
            sec_q <= 16'h0000;
        end
        else if (!t.expired)
        begin
            if (pre_q == 32'(CYCLES_PER_SEC - 1))
            begin
                pre_q <= 32'h0000_0000;
                sec_q <= sec_q + 16'h0001;
            end
            else
            begin
                pre_q <= pre_q + 32'h0000_0001;
            end
        end
    end
endmodule

//--- reg_master_model.sv
`timescale 1ns/1ns
// Bus master standing in front of the frame decoder
module reg_master_model
(
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_rstn,
    // Requests
    output logic [15:0] o_addr,
    output logic o_wr,
    output logic [15:0] o_wdata,
    output logic o_rd,
    // Answer
    input wire logic [15:0] i_rdata,
    input wire logic i_rvalid
);
    // Idle until the first request
    initial
    begin
        o_addr = 16'h0000;
        o_wr = 1'b0;
        o_wdata = 16'h0000;
        o_rd = 1'b0;
    end

    // Released lines carry inverted data so stale values never look valid
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge i_core_clk);
        o_addr <= a;
        o_wdata <= d;
        o_wr <= 1'b1;
        @(posedge i_core_clk);
        o_wr <= 1'b0;
        o_addr <= ~a;
        o_wdata <= ~d;
    endtask

    // Answer is sampled after the taking edge has landed
    task automatic rd(input logic [15:0] a, output logic [15:0] d, output logic ok);
        @(posedge i_core_clk);
        o_addr <= a;
        o_rd <= 1'b1;
        @(posedge i_core_clk);
        o_rd <= 1'b0;
        o_addr <= ~a;
        #1;
        ok = i_rvalid;
        d = i_rdata;
    endtask
endmodule

//--- bus_watchdog_failsafe_test.sv
`timescale 1ns/1ns
module bus_watchdog_failsafe_config_test;
    localparam int CPS = 4;
    logic i_core_clk = 1'b0;
    logic i_rstn = 1'b0;
    logic [15:0] reg_addr, reg_wdata, rdata, fs_pos;
    logic [15:0] other_bits = 16'h0000;
    logic [15:0] seed = 16'h0009;
    logic reg_wr, reg_rd, rvalid, fail_act, trip, origin, hold, move;
    logic power_fail = 1'b0;
    logic efs = 1'b0;
    logic [1:0] fail_mode;
    logic [15:0] alist[8] = '{16'h0068, 16'h006C, 16'h006D, 16'h0076,
        16'h00BD, 16'h00BE, 16'h0070, 16'h0000};
    logic [15:0] rst_a[3] = '{16'h0001, 16'h006D, 16'h00BD};
    int mdl[int];
    bit tmo_set, mtrip;
    int err_count, comparisons;

    // Clock, 4 ns period
    always #2 i_core_clk = ~i_core_clk;

    bus_watchdog_failsafe #(.CYCLES_PER_SEC(CPS)) i_bus_watchdog_failsafe
    (
        .i_core_clk(i_core_clk),
        .i_rstn(i_rstn),
        .i_reg_addr(reg_addr),
        .i_reg_wr(reg_wr),
        .i_reg_wdata(reg_wdata),
        .i_reg_rd(reg_rd),
        .o_reg_rdata(rdata),
        .o_reg_rvalid(rvalid),
        .i_other_fault_bits(other_bits),
        .i_power_fail(power_fail),
        .i_efs_variant(efs),
        .o_bus_fail_active(fail_act),
        .o_bus_fail_mode(fail_mode),
        .o_wdog_trip(trip),
        .o_setpoint_origin_select(origin),
        .o_bridge_hold(hold),
        .o_failsafe_move(move),
        .o_failsafe_position(fs_pos)
    );

    reg_master_model i_reg_master_model
    (
        .i_core_clk(i_core_clk),
        .i_rstn(i_rstn),
        .o_addr(reg_addr),
        .o_wr(reg_wr),
        .o_wdata(reg_wdata),
        .o_rd(reg_rd),
        .i_rdata(rdata),
        .i_rvalid(rvalid)
    );

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    // Expected read value; unmapped places read as deactivated
    function automatic logic [15:0] exp_rd(input logic [15:0] a);
        if (a == 16'h0068)
            return (other_bits & ~16'h0400) | {5'h00, mtrip, 10'h000};
        if (mdl.exists(a))
            return 16'(mdl[a]);
        return 16'hFFFF;
    endfunction

    task automatic end_sim();
        $display("comparisons %0d err_count %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        comparisons++;
        if (g !== e)
        begin
            err_count++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wt(input int n);
        repeat (n) @(posedge i_core_clk);
        #1;
    endtask

    // Write through the master and mirror it in the model
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        i_reg_master_model.wr(a, d);
        case (a)
            16'h006C:
                if (d <= 3)
                begin
                    if (d != 0 && !tmo_set && mdl[16'h6D] == 0)
                        mdl[16'h6D] = 120;
                    mdl[16'h6C] = d;
                end
            16'h006D:
                if (d <= 3600)
                begin
                    mdl[16'h6D] = d;
                    tmo_set = 1;
                end
            16'h0076: if (d <= 1) mdl[16'h76] = d;
            16'h00BD: if (d <= 10) mdl[16'hBD] = d;
            16'h00BE: if (d <= 10000) mdl[16'hBE] = d;
            16'h0000, 16'h0001: mtrip = 0;
            default: ;
        endcase
    endtask

    task automatic rdchk(input logic [15:0] a);
        logic [15:0] d;
        logic ok;
        i_reg_master_model.rd(a, d, ok);
        chk("rvalid", 16'h0001, {15'h0000, ok});
        chk("rdata", exp_rd(a), d);
    endtask

    task automatic ochk(input logic a, input logic t);
        chk("fail_active", {15'h0000, a}, {15'h0000, fail_act});
        chk("wdog_trip", {15'h0000, t}, {15'h0000, trip});
    endtask

    task automatic pchk(input logic h, input logic m);
        chk("bridge_hold", {15'h0000, h}, {15'h0000, hold});
        chk("fs_move", {15'h0000, m}, {15'h0000, move});
    endtask

    // Hang guard, far beyond the few hundred cycles the run needs
    initial
    begin
        #40000;
        err_count++;
        end_sim();
    end

    // Main sequence
    initial
    begin
        mdl[16'h6C] = 0;
        mdl[16'h6D] = 0;
        mdl[16'h76] = 1;
        mdl[16'hBD] = 0;
        mdl[16'hBE] = 0;
        repeat (3) @(posedge i_core_clk);
        i_rstn <= 1'b1;
        // Foreign bit ten set so the read must replace it with the trip flag
        other_bits <= seed | 16'h0400;
        foreach (alist[i]) rdchk(alist[i]);
        chk("origin", 16'h0001, {15'h0000, origin});
        wr(16'h0000, seed);
        wt(40);
        ochk(0, 0);
        for (int k = 0; k < 5; k++)
        begin
            wr(16'h006C, 16'(k));
            wt(1);
            chk("fail_mode", 16'(k > 3 ? 3 : k), {14'h0000, fail_mode});
        end
        rdchk(16'h006D);
        wr(16'h006D, 16'h0E11);
        rdchk(16'h006D);
        wr(16'h006D, 16'h0001);
        wr(16'h006C, 16'h0002);
        // Restart by setpoint, then by override or timeout write; other traffic does not restart
        foreach (rst_a[i])
        begin
            seed = lfsr(seed);
            wr(16'h0000, seed);
            wt(1);
            ochk(0, 0);
            wr(rst_a[i], 16'h0001);
            wt(4);
            mtrip = (i == 2);
            ochk(mtrip, mtrip);
            wt(4);
            mtrip = 1;
            ochk(1, 1);
            rdchk(16'h0068);
        end
        wr(16'h006C, 16'h0000);
        wr(16'h0000, seed);
        wt(8);
        mtrip = 1;
        ochk(0, 1);
        wr(16'h006D, 16'h0000);
        wr(16'h006C, 16'h0002);
        rdchk(16'h006D);
        wr(16'h0000, seed);
        wt(20);
        ochk(0, 0);
        wr(16'h006D, 16'h0001);
        wr(16'h0076, 16'h0002);
        wr(16'h0076, 16'h0000);
        rdchk(16'h0076);
        chk("origin", 16'h0000, {15'h0000, origin});
        wr(16'h0000, seed);
        wt(12);
        ochk(0, 0);
        // Power loss: refused on the plain variant, then bridged and moved
        wr(16'h00BE, 16'h2711);
        seed = lfsr(seed);
        wr(16'h00BE, seed % 16'h2711);
        wr(16'h00BD, 16'h0002);
        @(posedge i_core_clk) power_fail <= 1'b1;
        wt(20);
        pchk(0, 0);
        @(posedge i_core_clk) power_fail <= 1'b0;
        wt(6);
        @(posedge i_core_clk) efs <= 1'b1;
        wt(4);
        @(posedge i_core_clk) power_fail <= 1'b1;
        wt(5);
        pchk(1, 0);
        wt(4);
        pchk(1, 0);
        wt(5);
        pchk(0, 1);
        chk("fs_pos", 16'(mdl[16'hBE]), fs_pos);
        @(posedge i_core_clk) power_fail <= 1'b0;
        foreach (alist[i]) rdchk(alist[i]);
        end_sim();
    end
endmodule
